// File: design/mis_pkg.sv
// constants, types and bus map of the instruction execution unit
// Operation
// - power-down stops execution, gates clock, keeps data, clears timeout, sets power-down flag.
// - entering power-down clears the watchdog counter and its prescaler.
// - increment adds one to memory byte, into memory or accumulator; only zero flag.
// - jump loads program counter from address field and takes two cycles.
// - moves copy memory, immediate or accumulator; no flag changes; no-op changes nothing.
// - or combines accumulator with memory or immediate; result to accumulator or memory; zero only.
// - return pops program counter; immediate variant also loads accumulator; flags untouched.
// - return-from-interrupt with no interrupt pending pops program counter and sets global interrupt enable.
// - a pending interrupt at return-from-interrupt is serviced before the main program resumes.
// - rotate left moves bit 7 into bit 0; result to memory or accumulator; no flags.
// - rotate left through carry: old carry to bit 0, old bit 7 to carry.
// - rotate right moves bit 0 into bit 7; result to memory or accumulator; no flags.
// - rotate right through carry: old carry to bit 7, old bit 0 to carry.
// - subtract with carry: acc minus byte minus inverted carry; sets overflow, zero, aux carry, carry.
// - memory form of subtract with carry writes the difference to the memory byte.
// - after subtraction carry is 0 for negative result, 1 for zero or positive.
// - decrement-and-skip writes byte minus one back, skips next when zero; no flags.
// - accumulator form of decrement-and-skip leaves memory alone, skips when accumulator is zero.
// - a taken skip costs two cycles through a dummy cycle; otherwise execution continues.
// - set-memory writes all ones into the byte; flags untouched.
package mis_pkg;
    localparam int ADDR_W = 8;
    localparam int PC_W = 11;
    localparam int MEM_AW = 7;
    localparam int MEM_D = 128;
    localparam int STACK_D = 4;
    // register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0c;
    localparam logic [7:0] REG_MADDR = 8'h10;
    localparam logic [7:0] REG_MDATA = 8'h14;
    localparam logic [7:0] REG_WATCHDOG = 8'h18;
    localparam logic [7:0] REG_PUSH = 8'h1c;
    // command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_M_LSB = 8;
    localparam int CMD_ARG_LSB = 16;
    // status word fields (flags sit in bits 6:0)
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_HALT_BIT = 9;
    // reset values and fixed addresses
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [PC_W-1:0] INT_VECTOR = 11'h004;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [PC_W-1:0] PC_SKIP = 11'h002;
    localparam logic [7:0] WATCHDOG_RST = 8'h00;
    localparam logic [7:0] PRESC_LAST = 8'hff;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_INC = 6'h01, OP_INCA = 6'h02, OP_JMP = 6'h03,
        OP_MOVAM = 6'h04, OP_MOVAX = 6'h05, OP_MOVMA = 6'h06, OP_ORAM = 6'h07,
        OP_ORAX = 6'h08, OP_ORM = 6'h09, OP_RET = 6'h0a, OP_RETAX = 6'h0b,
        OP_RETI = 6'h0c, OP_RL = 6'h0d, OP_RLA = 6'h0e, OP_RLC = 6'h0f,
        OP_RLCA = 6'h10, OP_RR = 6'h11, OP_RRA = 6'h12, OP_RRC = 6'h13,
        OP_RRCA = 6'h14, OP_SBC = 6'h15, OP_SBCM = 6'h16, OP_SDZ = 6'h17,
        OP_SDZA = 6'h18, OP_SET = 6'h19, OP_HALT = 6'h1a
    } mis_op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DUMMY = 2'b01,
        ST_HALT = 2'b10
    } mis_state_t;

    typedef struct packed {
        logic global_interrupt_enable;
        logic watchdog_timeout_flag;
        logic power_down_flag;
        logic overflow_flag;
        logic z;
        logic aux_carry_flag;
        logic c;
    } mis_flags_t;

    localparam mis_flags_t FLAGS_RST = 7'h00;
endpackage

// File: design/mis_exec_unit.sv
// instruction execution unit with axi4-lite register access
`timescale 1ns/1ps
module mis_exec_unit (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // axi4-lite write channels
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [mis_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read channels
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [mis_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // core events
    input wire logic irq_pending,
    input wire logic wake_pin,
    output logic sys_clk_off
);
    import mis_pkg::*;

    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_commit;
    logic [31:0] wr_word;
    logic [7:0] acc;
    mis_flags_t flags;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack [0:STACK_D-1];
    logic [1:0] sp;
    logic [7:0] dmem [0:MEM_D-1];
    logic [MEM_AW-1:0] mem_ptr;
    mis_state_t state;
    logic [7:0] presc;
    logic [7:0] watchdog_counter;
    logic wake_meta;
    logic wake_s;
    mis_op_t ex_op;
    logic [MEM_AW-1:0] ex_m;
    logic [PC_W-1:0] ex_arg;
    logic [7:0] rd;
    logic [7:0] inc;
    logic [7:0] dec;
    logic [8:0] sub;
    logic [4:0] sub_lo;
    logic can_exec;
    logic go;
    logic [7:0] next_acc;
    mis_flags_t next_flags;
    logic next_mwe;
    logic [7:0] next_mdat;
    logic [PC_W-1:0] next_pc;
    logic next_two;
    logic next_pop;
    logic next_halt;

    // merge write data into a word by byte strobes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // true when a byte result is zero
    function automatic logic is_zero(input logic [7:0] b);
        return b == 8'h00;
    endfunction

    // true when an offset names a register
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CMD || a == REG_ACC || a == REG_STATUS || a == REG_PC ||
               a == REG_MADDR || a == REG_MDATA || a == REG_WATCHDOG || a == REG_PUSH;
    endfunction

    // write channel holding stages
    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign wr_commit = aw_full && w_full && !s_axi_bvalid;
    assign wr_word = wmerge(32'h0000_0000, wr_data, wr_strb);

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_full <= 1'b0;
            wr_addr <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_full) begin
                aw_full <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end else if (wr_commit) begin
                aw_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_full <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && !w_full) begin
                w_full <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end else if (wr_commit) begin
                w_full <= 1'b0;
            end
        end
    end

    // write response: refused commands report slverr, holes decerr
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (wr_commit) begin
                s_axi_bvalid <= 1'b1;
                if (!mapped(wr_addr)) begin
                    s_axi_bresp <= RESP_DECERR;
                end else if (wr_addr == REG_CMD && !can_exec) begin
                    s_axi_bresp <= RESP_SLVERR;
                end else begin
                    s_axi_bresp <= RESP_OKAY;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel, one cycle answer
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
                case (s_axi_araddr)
                    REG_ACC: s_axi_rdata <= {24'h000000, acc};
                    REG_STATUS: s_axi_rdata <= {22'h000000, state == ST_HALT, state == ST_DUMMY, 1'b0, flags};
                    REG_PC: s_axi_rdata <= {21'h000000, pc};
                    REG_MADDR: s_axi_rdata <= {25'h0000000, mem_ptr};
                    REG_MDATA: s_axi_rdata <= {24'h000000, dmem[mem_ptr]};
                    REG_WATCHDOG: s_axi_rdata <= {16'h0000, watchdog_counter, presc};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // command decode and operand fetch
    assign ex_op = mis_op_t'(wr_data[CMD_OP_LSB +: 6]);
    assign ex_m = wr_data[CMD_M_LSB +: MEM_AW];
    assign ex_arg = wr_data[CMD_ARG_LSB +: PC_W];
    assign rd = dmem[ex_m];
    assign inc = rd + 8'h01;
    assign dec = rd - 8'h01;
    assign sub = {1'b0, acc} + {1'b0, ~rd} + {8'h00, flags.c};
    assign sub_lo = {1'b0, acc[3:0]} + {1'b0, ~rd[3:0]} + {4'h0, flags.c};
    assign can_exec = state == ST_RUN;
    assign go = ce && wr_commit && wr_addr == REG_CMD && can_exec;

    // execution results
    always_comb begin
        next_acc = acc;
        next_flags = flags;
        next_mwe = 1'b0;
        next_mdat = rd;
        next_pc = pc + PC_STEP;
        next_two = 1'b0;
        next_pop = 1'b0;
        next_halt = 1'b0;
        case (ex_op)
            OP_INC: begin
                next_mwe = 1'b1;
                next_mdat = inc;
                next_flags.z = is_zero(inc);
            end
            OP_INCA: begin
                next_acc = inc;
                next_flags.z = is_zero(inc);
            end
            OP_JMP: begin
                next_pc = ex_arg;
                next_two = 1'b1;
            end
            OP_MOVAM: next_acc = rd;
            OP_MOVAX: next_acc = ex_arg[7:0];
            OP_MOVMA: begin
                next_mwe = 1'b1;
                next_mdat = acc;
            end
            OP_ORAM: begin
                next_acc = acc | rd;
                next_flags.z = is_zero(acc | rd);
            end
            OP_ORAX: begin
                next_acc = acc | ex_arg[7:0];
                next_flags.z = is_zero(acc | ex_arg[7:0]);
            end
            OP_ORM: begin
                next_mwe = 1'b1;
                next_mdat = acc | rd;
                next_flags.z = is_zero(acc | rd);
            end
            OP_RET, OP_RETAX: begin
                next_pc = stack[sp - 2'd1];
                next_pop = 1'b1;
                next_two = 1'b1;
                if (ex_op == OP_RETAX) begin
                    next_acc = ex_arg[7:0];
                end
            end
            OP_RETI: begin
                next_two = 1'b1;
                if (irq_pending) begin
                    // restored address goes straight back on the stack for the handler
                    next_pc = INT_VECTOR;
                    next_flags.global_interrupt_enable = 1'b0;
                end else begin
                    next_pc = stack[sp - 2'd1];
                    next_pop = 1'b1;
                    next_flags.global_interrupt_enable = 1'b1;
                end
            end
            OP_RL: begin
                next_mwe = 1'b1;
                next_mdat = {rd[6:0], rd[7]};
            end
            OP_RLA: next_acc = {rd[6:0], rd[7]};
            OP_RLC, OP_RLCA: begin
                next_flags.c = rd[7];
                next_mdat = {rd[6:0], flags.c};
                next_mwe = ex_op == OP_RLC;
                next_acc = ex_op == OP_RLCA ? {rd[6:0], flags.c} : acc;
            end
            OP_RR: begin
                next_mwe = 1'b1;
                next_mdat = {rd[0], rd[7:1]};
            end
            OP_RRA: next_acc = {rd[0], rd[7:1]};
            OP_RRC, OP_RRCA: begin
                next_flags.c = rd[0];
                next_mdat = {flags.c, rd[7:1]};
                next_mwe = ex_op == OP_RRC;
                next_acc = ex_op == OP_RRCA ? {flags.c, rd[7:1]} : acc;
            end
            OP_SBC, OP_SBCM: begin
                next_flags.c = sub[8];
                next_flags.aux_carry_flag = sub_lo[4];
                next_flags.z = is_zero(sub[7:0]);
                next_flags.overflow_flag = (acc[7] ^ rd[7]) & (sub[7] ^ acc[7]);
                next_mdat = sub[7:0];
                next_mwe = ex_op == OP_SBCM;
                next_acc = ex_op == OP_SBC ? sub[7:0] : acc;
            end
            OP_SDZ, OP_SDZA: begin
                next_mdat = dec;
                next_mwe = ex_op == OP_SDZ;
                next_acc = ex_op == OP_SDZA ? dec : acc;
                if (is_zero(dec)) begin
                    next_pc = pc + PC_SKIP;
                    next_two = 1'b1;
                end
            end
            OP_SET: begin
                next_mwe = 1'b1;
                next_mdat = 8'hff;
            end
            OP_HALT: begin
                next_halt = 1'b1;
                next_flags.power_down_flag = 1'b1;
                next_flags.watchdog_timeout_flag = 1'b0;
            end
            default: next_pc = pc + PC_STEP; // unknown codes act as no-op
        endcase
    end

    // sequencer: run, dummy cycle, power-down
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_RUN;
        end else if (ce) begin
            case (state)
                ST_RUN: begin
                    if (go && next_halt) begin
                        state <= ST_HALT;
                    end else if (go && next_two) begin
                        state <= ST_DUMMY;
                    end
                end
                ST_DUMMY: state <= ST_RUN;
                ST_HALT: begin
                    if (wake_s) begin
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    assign sys_clk_off = state == ST_HALT;

    // accumulator, flags and program counter
    always_ff @(posedge clk) begin
        if (rst) begin
            acc <= ACC_RST;
            flags <= FLAGS_RST;
            pc <= PC_RST;
        end else if (ce) begin
            if (go) begin
                acc <= next_acc;
                flags <= next_flags;
                pc <= next_pc;
            end else if (wr_commit && wr_addr == REG_ACC) begin
                acc <= wr_word[7:0];
            end else if (wr_commit && wr_addr == REG_STATUS) begin
                flags <= mis_flags_t'(wr_word[6:0]);
            end else if (wr_commit && wr_addr == REG_PC) begin
                pc <= wr_word[PC_W-1:0];
            end
        end
    end

    // four-level circular return stack
    always_ff @(posedge clk) begin
        if (rst) begin
            sp <= 2'd0;
        end else if (ce) begin
            if (go && next_pop) begin
                sp <= sp - 2'd1;
            end else if (wr_commit && wr_addr == REG_PUSH) begin
                stack[sp] <= wr_word[PC_W-1:0];
                sp <= sp + 2'd1;
            end
        end
    end

    // data memory and its bus pointer
    always_ff @(posedge clk) begin
        if (ce) begin
            if (go && next_mwe) begin
                dmem[ex_m] <= next_mdat;
            end else if (wr_commit && wr_addr == REG_MDATA && wr_strb[0]) begin
                dmem[mem_ptr] <= wr_data[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_ptr <= '0;
        end else if (ce && wr_commit && wr_addr == REG_MADDR) begin
            mem_ptr <= wr_word[MEM_AW-1:0];
        end
    end

    // watchdog prescaler and counter, frozen while powered down
    always_ff @(posedge clk) begin
        if (rst) begin
            presc <= WATCHDOG_RST;
            watchdog_counter <= WATCHDOG_RST;
        end else if (ce) begin
            if (go && next_halt) begin
                presc <= WATCHDOG_RST;
                watchdog_counter <= WATCHDOG_RST;
            end else if (state != ST_HALT) begin
                presc <= presc + 8'h01;
                if (presc == PRESC_LAST) begin
                    watchdog_counter <= watchdog_counter + 8'h01;
                end
            end
        end
    end

    // wake pin synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_meta <= 1'b0;
            wake_s <= 1'b0;
        end else if (ce) begin
            wake_meta <= wake_pin;
            wake_s <= wake_meta;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_jump_load;
        pc == $past(ex_arg) && state == ST_DUMMY;
    endsequence
    sequence s_back_to_run;
        state == ST_RUN;
    endsequence

    property p_halt_flags;
        go && ex_op == OP_HALT |=> flags.power_down_flag && !flags.watchdog_timeout_flag && sys_clk_off;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("power-down flags wrong");
    property p_halt_watchdog;
        go && ex_op == OP_HALT |=> watchdog_counter == 8'h00 && presc == 8'h00;
    endproperty
    a_halt_watchdog: assert property (p_halt_watchdog) else $error("watchdog not cleared");
    property p_inca;
        go && ex_op == OP_INCA |=> acc == $past(rd) + 8'h01 && flags.z == ($past(rd) == 8'hff);
    endproperty
    a_inca: assert property (p_inca) else $error("increment result wrong");
    property p_jump;
        ce && go && ex_op == OP_JMP ##1 ce |-> s_jump_load ##1 s_back_to_run;
    endproperty
    a_jump: assert property (p_jump) else $error("jump timing wrong");
    property p_move_flags;
        go && (ex_op == OP_MOVAM || ex_op == OP_MOVMA || ex_op == OP_NOP) |=> flags == $past(flags);
    endproperty
    a_move_flags: assert property (p_move_flags) else $error("move changed flags");
    property p_reti;
        go && ex_op == OP_RETI && !irq_pending |=> flags.global_interrupt_enable && sp == $past(sp) - 2'd1;
    endproperty
    a_reti: assert property (p_reti) else $error("interrupt enable not set");
    property p_reti_pending;
        go && ex_op == OP_RETI && irq_pending |=> pc == INT_VECTOR && sp == $past(sp);
    endproperty
    a_reti_pending: assert property (p_reti_pending) else $error("pending interrupt not taken");
    property p_rla;
        go && ex_op == OP_RLA |=> acc == {$past(rd[6:0]), $past(rd[7])} && flags == $past(flags);
    endproperty
    a_rla: assert property (p_rla) else $error("rotate left wrong");
    property p_sbc_carry;
        go && ex_op == OP_SBC |=> flags.c == ({1'b0, $past(acc)} >= {1'b0, $past(rd)} + {8'h00, !$past(flags.c)});
    endproperty
    a_sbc_carry: assert property (p_sbc_carry) else $error("borrow flag wrong");
    property p_skip;
        go && ex_op == OP_SDZA && rd == 8'h01 |=> state == ST_DUMMY && pc == $past(pc) + PC_SKIP;
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");
endmodule

// File: tb/mis_exec_unit_test.sv
// self-checking bench for the instruction execution unit
`timescale 1ns/1ps
module mis_exec_unit_test;
    import mis_pkg::*;
    typedef struct packed {
        logic [7:0] op, acc, mem, st;
        logic [11:0] arg;
        logic [7:0] ea, em, es;
        logic [11:0] epc;
    } mis_row_t;
    logic clk, rst, awv, wv, br, arv, rr, irq, wake;
    logic awr, wrd, bv, arr, rv, off;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, d;
    logic [1:0] bresp, rresp;
    int n_fail, samples_checked, cycles;
    mis_row_t rows[$];
    mis_row_t r;

    mis_exec_unit i_dut (
        .clk(clk), .rst(rst), .ce(1'b1),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .irq_pending(irq), .wake_pin(wake), .sys_clk_off(off)
    );

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bus write: address and data offered together, bready held until the response
    task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= v;
        br <= 1'b1;
        forever begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            if (bv) begin
                br <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
                break;
            end
        end
    endtask

    // bus read: rready held until rvalid is seen
    task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rr <= 1'b1;
        forever begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                rr <= 1'b0;
                v = rdat;
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                break;
            end
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] v;
        axr(a, v, RESP_OKAY);
        chk(nm, e, v);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // main sequence
    initial begin
        rst <= 1'b1;
        {awv, wv, br, arv, rr, irq, wake} <= 7'h0;
        {awa, ara, wd} <= 48'h0;
        rows = '{80'h01_11_ff_00_000_11_00_04_011, 80'h02_00_7f_04_000_80_7f_00_011,
            80'h03_22_33_4b_2ab_22_33_4b_2ab, 80'h04_00_5a_0f_000_5a_5a_0f_011,
            80'h05_00_44_00_033_33_44_00_011, 80'h06_c3_00_30_000_c3_c3_30_011,
            80'h07_00_00_00_000_00_00_04_011, 80'h08_10_00_04_001_11_00_00_011,
            80'h09_f0_0f_00_000_f0_ff_00_011, 80'h00_12_34_4b_000_12_34_4b_011,
            80'h0a_12_34_0f_000_12_34_0f_123, 80'h0b_12_34_0f_099_99_34_0f_123,
            80'h0c_00_00_01_000_00_00_41_123, 80'h0d_00_81_01_000_00_03_01_011,
            80'h0e_00_81_04_000_03_81_04_011, 80'h0f_00_80_00_000_00_00_01_011,
            80'h10_00_01_05_000_03_01_04_011, 80'h11_00_01_00_000_00_80_00_011,
            80'h12_00_02_00_000_01_02_00_011, 80'h13_00_01_00_000_00_00_01_011,
            80'h14_00_02_01_000_81_02_00_011, 80'h15_10_01_01_000_0f_01_01_011,
            80'h15_00_01_00_000_fe_01_00_011, 80'h15_80_01_01_000_7f_01_09_011,
            80'h16_05_05_01_000_05_00_07_011, 80'h17_00_01_0f_000_00_00_0f_012,
            80'h17_00_02_00_000_00_01_00_011, 80'h18_55_01_00_000_00_01_00_012,
            80'h19_00_00_3f_000_00_ff_3f_011};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rc(REG_ACC, 32'h0, "acc");
        rc(REG_STATUS, 32'h0, "status");
        rc(REG_PC, 32'h0, "pc");
        axw(REG_MADDR, 32'h5, RESP_OKAY);
        foreach (rows[i]) begin
            r = rows[i];
            axw(REG_PC, 32'h10, RESP_OKAY);
            axw(REG_PUSH, 32'h123, RESP_OKAY);
            axw(REG_ACC, {24'h0, r.acc}, RESP_OKAY);
            axw(REG_STATUS, {24'h0, r.st}, RESP_OKAY);
            axw(REG_MDATA, {24'h0, r.mem}, RESP_OKAY);
            axw(REG_CMD, {5'h0, r.arg[10:0], 1'b0, 7'h05, r.op}, RESP_OKAY);
            rc(REG_ACC, {24'h0, r.ea}, "acc");
            rc(REG_MDATA, {24'h0, r.em}, "mem");
            rc(REG_STATUS, {24'h0, r.es}, "status");
            rc(REG_PC, {20'h0, r.epc}, "pc");
        end
        axw(REG_ACC, 32'h5c, RESP_OKAY);
        axw(REG_STATUS, 32'h20, RESP_OKAY);
        axw(REG_CMD, {26'h0, OP_HALT}, RESP_OKAY);
        chk("clk_off", 32'h1, {31'h0, off});
        rc(REG_STATUS, 32'h210, "status");
        rc(REG_WATCHDOG, 32'h0, "watchdog");
        axw(REG_CMD, {26'h0, OP_INCA}, RESP_SLVERR);
        rc(REG_ACC, 32'h5c, "acc");
        wake <= 1'b1;
        repeat (8) @(posedge clk);
        wake <= 1'b0;
        chk("clk_off", 32'h0, {31'h0, off});
        irq <= 1'b1;
        axw(REG_PUSH, 32'h123, RESP_OKAY);
        axw(REG_CMD, {26'h0, OP_RETI}, RESP_OKAY);
        rc(REG_PC, {21'h0, INT_VECTOR}, "pc");
        irq <= 1'b0;
        axw(REG_CMD, {26'h0, OP_RET}, RESP_OKAY);
        rc(REG_PC, 32'h123, "pc");
        axw(8'h20, 32'h0, RESP_DECERR);
        axr(8'h20, d, RESP_DECERR);
        chk("rdata", 32'h0, d);
        end_of_test();
    end
endmodule
